// ===== shared/irq_combiner_pkg.sv
// constants, register map and field layout of the level interrupt combiner
package irq_combiner_pkg;
  localparam int unsigned LEVELS       = 32;
  localparam int unsigned PIN_COUNT    = 7;
  localparam int unsigned PBUS_LINES   = 8;
  localparam int unsigned PBUS_SLOTS   = 4;
  localparam int unsigned PBUS_LATENCY = 4;

  // register byte addresses
  localparam logic [31:0] PEND_ADDR    = 32'h8007efa0;
  localparam logic [31:0] AND_ADDR     = 32'h8007efa4;
  localparam logic [31:0] MASK_ADDR    = 32'h8007efa8;
  localparam logic [31:0] MAP_ADDR     = 32'h8007efac;
  localparam logic [31:0] CFG_ADDR     = 32'h8007efb0;
  localparam logic [31:0] EVT_ST_ADDR  = 32'h8007efb4;
  localparam logic [31:0] EVT_CLR_ADDR = 32'h8007efb8;
  localparam logic [31:0] EVT_EN_ADDR  = 32'h8007efbc;

  localparam logic [31:0] RESET_WORD   = 32'h00000000;

  // level map: big-endian bits 15 and 16 read as zero
  localparam logic [31:0] MAP_WMASK    = 32'hfffe7fff;
  localparam int unsigned MAP_PIN0_LSB = 27;
  localparam int unsigned MAP_PIN1_LSB = 22;
  localparam int unsigned MAP_PIN2_LSB = 17;
  localparam int unsigned MAP_LB0_LSB  = 10;
  localparam int unsigned MAP_LB1_LSB  = 5;
  localparam int unsigned MAP_TICK_LSB = 0;

  // levels of the pins without a programmable field
  localparam logic [4:0]  PIN3_LEVEL   = 5'h06;
  localparam logic [4:0]  PIN4_LEVEL   = 5'h08;
  localparam logic [4:0]  PIN5_LEVEL   = 5'h0a;
  localparam logic [4:0]  PIN6_LEVEL   = 5'h0c;

  // configuration register layout
  localparam logic [31:0] CFG_WMASK    = 32'h3fffffff;
  localparam int unsigned CFG_MUX_LSB  = 0;
  localparam int unsigned CFG_FUNC_LSB = 2;
  localparam int unsigned CFG_EDGE_LSB = 16;

  localparam logic [1:0]  FUNC_TO_CPU  = 2'h2;
  localparam logic [1:0]  FUNC_TO_CTRL = 2'h3;
  localparam logic [1:0]  EDGE_LEVEL   = 2'h0;

  // event status bits
  localparam int unsigned EVT_W        = 2;
  localparam int unsigned EVT_RISE     = 0;
  localparam int unsigned EVT_BUSERR   = 1;
endpackage : irq_combiner_pkg

// ===== logic/pbus_slot_demux.sv
// demultiplexer for the time-shared peripheral request lines
`timescale 1ns/1ns
module pbus_slot_demux #(
  parameter int unsigned LINES = irq_combiner_pkg::PBUS_LINES,
  parameter int unsigned SLOTS = irq_combiner_pkg::PBUS_SLOTS
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [1:0]             mux_sel,
  input  wire logic [LINES-1:0]       lines,
  output logic      [1:0]             slot_r,
  output logic      [LINES*SLOTS-1:0] levels
);
  import irq_combiner_pkg::*;

  logic [LINES*SLOTS-1:0] held_r;
  logic [LINES*SLOTS-1:0] held_nxt;
  logic [1:0]             slot_nxt;

  // the two-bit select can only address four slots
  if (SLOTS != 4 || LINES == 0) begin : g_bad
    $error("pbus_slot_demux needs four slots and at least one line");
  end

  // last slot equals the select value; mode 00 stays in slot 0
  assign slot_nxt = (slot_r >= mux_sel) ? 2'h0 : slot_r + 2'h1;

  // live lines override the held copy so latency stays within a round
  always_comb begin
    levels = held_r;
    levels[slot_r*LINES +: LINES] = lines;
  end

  // slots beyond the select are dropped so a mode change leaves no ghosts
  always_comb begin
    held_nxt = levels;
    for (int s = 0; s < SLOTS; s++) begin
      if (s > int'(mux_sel)) begin
        held_nxt[s*LINES +: LINES] = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_r <= 2'h0;
      held_r <= '0;
    end else begin
      slot_r <= slot_nxt;
      held_r <= held_nxt;
    end
  end
endmodule : pbus_slot_demux

// ===== logic/level_interrupt_combiner.sv
// level interrupt combiner with APB register slave
`timescale 1ns/1ns
module level_interrupt_combiner (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave port
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // request sources
  input  wire logic        tick_req,
  input  wire logic [6:0]  ext_req_n,
  input  wire logic [6:0]  edge_status,
  input  wire logic [7:0]  pbus_req,
  // towards the peripherals and the core
  output logic      [1:0]  pbus_slot,
  output logic             cpu_irq,
  output logic             pin_direct_req,
  output logic             evt_irq
);
  import irq_combiner_pkg::*;

  // one-hot level bit in big-endian order, empty when not requested
  function automatic logic [31:0] level_bit(input logic [4:0] lvl,
                                            input logic       req);
    level_bit = req ? (32'h80000000 >> lvl) : 32'h00000000;
  endfunction : level_bit

  // turn a level-indexed vector into register bit order
  function automatic logic [31:0] to_reg_order(input logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      to_reg_order[31-i] = v[i];
    end
  endfunction : to_reg_order

  // architectural state
  logic [31:0] pending_r;
  logic [31:0] mask_r;
  logic [31:0] map_r;
  logic [31:0] cfg_r;
  logic [EVT_W-1:0] evt_stat_r;
  logic [EVT_W-1:0] evt_en_r;
  // registered bus answer and outputs
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        cpu_irq_r;
  logic        pin_direct_r;
  logic        evt_irq_r;

  // next-state values and event strobes
  logic [31:0] pending_nxt;
  logic [31:0] mask_nxt;
  logic [31:0] map_nxt;
  logic [31:0] cfg_nxt;
  logic [EVT_W-1:0] evt_stat_nxt;
  logic [EVT_W-1:0] evt_en_nxt;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  // bus decode
  // ready is part of the access term so a stalled master never writes twice
  wire setup_ph = psel & ~penable;
  wire access   = psel & penable & pready_r;
  wire wr_acc   = access & pwrite;

  // whole-address compare, so the block answers at no alias
  wire hit_pend = (paddr == PEND_ADDR);
  wire hit_and  = (paddr == AND_ADDR);
  wire hit_mask = (paddr == MASK_ADDR);
  wire hit_map  = (paddr == MAP_ADDR);
  wire hit_cfg  = (paddr == CFG_ADDR);
  wire hit_est  = (paddr == EVT_ST_ADDR);
  wire hit_eclr = (paddr == EVT_CLR_ADDR);
  wire hit_een  = (paddr == EVT_EN_ADDR);
  wire hit_any  = hit_pend | hit_and | hit_mask | hit_map |
                  hit_cfg | hit_est | hit_eclr | hit_een;

  // write strobes, one per writable register
  wire wr_mask  = wr_acc & hit_mask;
  wire wr_map   = wr_acc & hit_map;
  wire wr_cfg   = wr_acc & hit_cfg;
  wire wr_eclr  = wr_acc & hit_eclr;
  wire wr_een   = wr_acc & hit_een;

  // configuration fields
  // field slices are fixed wiring, no logic of their own
  wire [1:0]  mux_sel   = cfg_r[CFG_MUX_LSB +: 2];
  wire [13:0] func_sel  = cfg_r[CFG_FUNC_LSB +: 14];
  wire [13:0] edge_sel  = cfg_r[CFG_EDGE_LSB +: 14];

  // programmable level fields of the level map
  wire [4:0]  pin0_lvl  = map_r[MAP_PIN0_LSB +: 5];
  wire [4:0]  pin1_lvl  = map_r[MAP_PIN1_LSB +: 5];
  wire [4:0]  pin2_lvl  = map_r[MAP_PIN2_LSB +: 5];
  wire [4:0]  tick_lvl  = map_r[MAP_TICK_LSB +: 5];

  // per-pin level table: three programmable, four fixed
  logic [4:0] pin_lvl [PIN_COUNT];
  assign pin_lvl[0] = pin0_lvl;
  assign pin_lvl[1] = pin1_lvl;
  assign pin_lvl[2] = pin2_lvl;
  assign pin_lvl[3] = PIN3_LEVEL;
  assign pin_lvl[4] = PIN4_LEVEL;
  assign pin_lvl[5] = PIN5_LEVEL;
  assign pin_lvl[6] = PIN6_LEVEL;

  // pin qualification
  // edge latches live in the pin logic outside; only their outputs come in
  // a pin in level mode is its own request; otherwise the edge latch is
  logic [PIN_COUNT-1:0] pin_act;
  logic [PIN_COUNT-1:0] to_ctrl;
  logic [PIN_COUNT-1:0] to_cpu;
  always_comb begin
    for (int k = 0; k < PIN_COUNT; k++) begin
      pin_act[k] = (edge_sel[2*k +: 2] == EDGE_LEVEL) ? ~ext_req_n[k]
                                                      : edge_status[k];
      to_ctrl[k] = pin_act[k] & (func_sel[2*k +: 2] == FUNC_TO_CTRL);
      to_cpu[k]  = pin_act[k] & (func_sel[2*k +: 2] == FUNC_TO_CPU);
    end
  end

  // peripheral request lines
  // the demultiplexer owns the slot counter that the peripherals follow
  logic [31:0] pbus_levels;
  wire  [31:0] pbus_bits = to_reg_order(pbus_levels);

  // live lines of the current slot, held copies of the others
  pbus_slot_demux #(
    .LINES (PBUS_LINES),
    .SLOTS (PBUS_SLOTS)
  ) u_demux (
    .clk     (clk),
    .rst_n   (rst_n),
    .mux_sel (mux_sel),
    .lines   (pbus_req),
    .slot_r  (pbus_slot),
    .levels  (pbus_levels)
  );

  // level combination
  // pending is rebuilt every cycle, so a dropped source clears its bit
  // all sources simply OR onto their level; no source outranks another
  always_comb begin
    pending_nxt = level_bit(tick_lvl, tick_req) | pbus_bits;
    for (int k = 0; k < PIN_COUNT; k++) begin
      pending_nxt = pending_nxt | level_bit(pin_lvl[k], to_ctrl[k]);
    end
  end

  // the local-bus fields are stored but no source is wired to them
  assign mask_nxt = wr_mask ? pwdata : mask_r;
  assign map_nxt  = wr_map ? (pwdata & MAP_WMASK) : map_r;
  assign cfg_nxt  = wr_cfg ? (pwdata & CFG_WMASK) : cfg_r;
  assign evt_en_nxt = wr_een ? pwdata[EVT_W-1:0] : evt_en_r;

  // event status: a set in the clearing cycle survives
  // a rising level and a bus error each set one sticky bit
  assign evt_set[EVT_RISE]   = |(pending_nxt & ~pending_r);
  assign evt_set[EVT_BUSERR] = setup_ph & ~hit_any;
  // clear register is write-one-to-clear and keeps no state
  assign evt_clr             = wr_eclr ? pwdata[EVT_W-1:0] : '0;
  assign evt_stat_nxt        = (evt_stat_r & ~evt_clr) | evt_set;

  // read data, prepared in the setup cycle
  // unmapped and write-only offsets read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_pend) rd_mux = pending_r;
    if (hit_and)  rd_mux = pending_r & mask_r;
    if (hit_mask) rd_mux = mask_r;
    if (hit_map)  rd_mux = map_r;
    if (hit_cfg)  rd_mux = cfg_r;
    if (hit_est)  rd_mux = {{(32-EVT_W){1'b0}}, evt_stat_r};
    if (hit_een)  rd_mux = {{(32-EVT_W){1'b0}}, evt_en_r};
  end

  // state registers
  // every architectural register clears together on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_r  <= RESET_WORD;
      mask_r     <= RESET_WORD;
      map_r      <= RESET_WORD;
      cfg_r      <= RESET_WORD;
      evt_stat_r <= '0;
      evt_en_r   <= '0;
    end else begin
      pending_r  <= pending_nxt;
      mask_r     <= mask_nxt;
      map_r      <= map_nxt;
      cfg_r      <= cfg_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_en_r   <= evt_en_nxt;
    end
  end

  // core and event requests follow the next state so the core sees the same cycle as the
  // and register; costs a deeper cone but saves a clock of latency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq_r    <= 1'b0;
      pin_direct_r <= 1'b0;
      evt_irq_r    <= 1'b0;
    end else begin
      cpu_irq_r    <= |(pending_nxt & mask_nxt);
      pin_direct_r <= |to_cpu;
      evt_irq_r    <= |(evt_stat_nxt & evt_en_nxt);
    end
  end

  // no wait state: ready rises for the first access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= setup_ph ? rd_mux : 32'h00000000;
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph & ~hit_any;
    end
  end

  // outputs are the flip-flops themselves, no gate behind them
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign cpu_irq        = cpu_irq_r;
  assign pin_direct_req = pin_direct_r;
  assign evt_irq        = evt_irq_r;

  // checks
  // assertions sample at the rising edge and sleep during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tick_level: assert property (
    tick_req |=> pending_r[31 - $past(tick_lvl)]
  ) else $error("timer request missing from its level");

  chk_mask_hold: assert property (
    !wr_mask |=> $stable(mask_r)
  ) else $error("enable mask changed without a write");

  chk_and_read: assert property (
    (setup_ph && !pwrite && hit_and) |=> prdata == $past(pending_r & mask_r)
  ) else $error("and register read is not pending and mask");

  chk_core_irq: assert property (
    cpu_irq == |(pending_r & mask_r)
  ) else $error("core request disagrees with enabled pending levels");

  chk_map_write: assert property (
    wr_map |=> map_r == ($past(pwdata) & MAP_WMASK)
  ) else $error("level map write not stored as given");

  chk_fixed_level: assert property (
    (!ext_req_n[3] && func_sel[7:6] == FUNC_TO_CTRL && edge_sel[7:6] == EDGE_LEVEL)
      |=> pending_r[31 - 6]
  ) else $error("pin three not on level six");

  chk_pbus_direct: assert property (
    (mux_sel == 2'h0 && pbus_slot == 2'h0 && pbus_req[0]) |=> pending_r[31]
  ) else $error("peripheral line zero not on level zero");

  chk_pin_route: assert property (
    (!ext_req_n[0] && func_sel[1:0] == FUNC_TO_CPU && edge_sel[1:0] == EDGE_LEVEL)
      |=> pin_direct_req
  ) else $error("pin routed to core did not raise direct request");

  chk_evt_sticky: assert property (
    (evt_stat_r[EVT_RISE] && !(wr_eclr && pwdata[EVT_RISE])) |=> evt_stat_r[EVT_RISE]
  ) else $error("event status bit lost without a clear");

  // bus answer shape and event request
  chk_pend_read: assert property (
    (setup_ph && !pwrite && hit_pend) |=> prdata == $past(pending_r)
  ) else $error("pending read is not the pending register");

  chk_ready_single: assert property (
    pready |=> !pready
  ) else $error("ready stood for more than one cycle");

  chk_err_ready: assert property (
    pslverr |-> pready
  ) else $error("error flagged outside the access cycle");

  chk_idle_data: assert property (
    !pready |-> prdata == 32'h00000000
  ) else $error("read data not zero outside the access cycle");

  chk_evt_irq: assert property (
    evt_irq == |(evt_stat_r & evt_en_r)
  ) else $error("event request disagrees with enabled status");

  // peripheral slot sequencing
  chk_slot_wrap: assert property (
    (pbus_slot >= mux_sel) |=> pbus_slot == 2'h0
  ) else $error("slot counter did not wrap at the select value");

  chk_slot_step: assert property (
    (pbus_slot < mux_sel) |=> pbus_slot == $past(pbus_slot) + 2'h1
  ) else $error("slot counter skipped a slot");

  // register holding and fixed routing
  chk_pin6_level: assert property (
    (!ext_req_n[6] && func_sel[13:12] == FUNC_TO_CTRL && edge_sel[13:12] == EDGE_LEVEL)
      |=> pending_r[31 - 12]
  ) else $error("pin six not on level twelve");

  chk_map_hold: assert property (
    !wr_map |=> $stable(map_r)
  ) else $error("level map changed without a write");

  chk_cfg_hold: assert property (
    !wr_cfg |=> $stable(cfg_r)
  ) else $error("configuration changed without a write");

  cov_irq_raise:  cover property ($rose(cpu_irq));
  cov_mux4_slot:  cover property (mux_sel == 2'h3 && pbus_slot == 2'h3);
  cov_set_clear:  cover property (wr_eclr && evt_set[EVT_RISE]);
  cov_bus_error:  cover property (pslverr && pready);
  cov_edge_pin:   cover property (to_ctrl[3] && edge_sel[7:6] != EDGE_LEVEL);
endmodule : level_interrupt_combiner

// ===== testbench/periph_core_model.sv
// far-side model: slot-driven peripheral requests and the core's interrupt input
`timescale 1ns/1ns
module periph_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  pbus_slot,
  input  wire logic [31:0] periph_lvls,
  input  wire logic        cpu_irq,
  output logic      [7:0]  pbus_req,
  output int               irq_rises
);
  logic irq_q_r;

  // a peripheral drives only its lines of the current slot; slot s line j is level 8*s+j
  assign pbus_req = periph_lvls[{pbus_slot, 3'b000} +: 8];

  // core side only counts requests, it never touches the mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q_r   <= 1'b0;
      irq_rises <= 0;
    end else begin
      irq_q_r <= cpu_irq;
      if (cpu_irq && !irq_q_r) irq_rises <= irq_rises + 1;
    end
  end
endmodule : periph_core_model

// ===== testbench/tb_level_interrupt_combiner.sv
// self-checking bench of the level interrupt combiner over apb
`timescale 1ns/1ns
module tb_level_interrupt_combiner;
  import irq_combiner_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, tick_req;
  logic        cpu_irq, pin_direct_req, evt_irq;
  logic [31:0] paddr, pwdata, prdata, periph_lvls, rd, m;
  logic [6:0]  ext_req_n, edge_status;
  logic [7:0]  pbus_req;
  logic [1:0]  pbus_slot;
  logic        er;
  logic [4:0]  fix_lvl [3:6];
  int          mismatches, check_count, irq_rises;

  level_interrupt_combiner level_interrupt_combiner_i (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_req(tick_req),
    .ext_req_n(ext_req_n), .edge_status(edge_status), .pbus_req(pbus_req),
    .pbus_slot(pbus_slot), .cpu_irq(cpu_irq), .pin_direct_req(pin_direct_req),
    .evt_irq(evt_irq));
  periph_core_model periph_core_model_i (.clk(clk), .rst_n(rst_n), .pbus_slot(pbus_slot),
    .periph_lvls(periph_lvls), .cpu_irq(cpu_irq), .pbus_req(pbus_req),
    .irq_rises(irq_rises));

  // 25 MHz clock
  always #20 clk = ~clk;

  function automatic logic [31:0] lb(input int n);
    lb = 32'h80000000 >> n;
  endfunction : lb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic is_wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= is_wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rchk

  // registered outputs need two edges after the cause has landed
  task automatic ochk(input logic got_sel, input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, got_sel ? evt_irq : cpu_irq}, {31'h0, exp});
  endtask : ochk

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; tick_req = 1'b0; ext_req_n = 7'h7f;
    edge_status = 7'h00; periph_lvls = 32'h0; mismatches = 0; check_count = 0;
    fix_lvl[3] = PIN3_LEVEL; fix_lvl[4] = PIN4_LEVEL;
    fix_lvl[5] = PIN5_LEVEL; fix_lvl[6] = PIN6_LEVEL;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk(PEND_ADDR, 32'h0);
    rchk(AND_ADDR, 32'h0);
    rchk(MASK_ADDR, 32'h0);
    rchk(MAP_ADDR, 32'h0);
    wr(MASK_ADDR, 32'ha5a5a5a5);
    rchk(MASK_ADDR, 32'ha5a5a5a5);
    wr(PEND_ADDR, 32'hffffffff);
    rchk(PEND_ADDR, 32'h0);
    wr(MASK_ADDR, 32'h0);
    wr(CFG_ADDR, 32'h0000fffc);
    // fixed-level pins, one at a time
    for (int k = 3; k <= 6; k++) begin
      ext_req_n[k] <= 1'b0;
      rchk(PEND_ADDR, lb(fix_lvl[k]));
      ext_req_n[k] <= 1'b1;
    end
    wr(MAP_ADDR, 32'hffffffff);
    rchk(MAP_ADDR, MAP_WMASK);
    m = {5'd1, 5'd2, 5'd3, 2'b00, 5'd20, 5'd20, 5'd4};
    wr(MAP_ADDR, m);
    rchk(MAP_ADDR, m);
    // level 20 in the unused fields must never show up
    for (int k = 0; k < 3; k++) begin
      ext_req_n[k] <= 1'b0;
      rchk(PEND_ADDR, lb(k + 1));
      ext_req_n[k] <= 1'b1;
    end
    tick_req <= 1'b1;
    rchk(PEND_ADDR, lb(4));
    tick_req <= 1'b0;
    wr(MAP_ADDR, {5'd6, 27'h0});
    ext_req_n <= 7'h76;
    rchk(PEND_ADDR, lb(6));
    ext_req_n[3] <= 1'b1;
    rchk(PEND_ADDR, lb(6));
    wr(MASK_ADDR, lb(6) | lb(9));
    rchk(AND_ADDR, lb(6));
    ochk(1'b0, 1'b1);
    rchk(MASK_ADDR, lb(6) | lb(9));
    tick_req <= 1'b1;
    rchk(PEND_ADDR, lb(0) | lb(6));
    rchk(AND_ADDR, lb(6));
    tick_req <= 1'b0;
    wr(MASK_ADDR, lb(0));
    ochk(1'b0, 1'b0);
    ext_req_n <= 7'h7f;
    wr(CFG_ADDR, 32'h0000fff8);
    ext_req_n[0] <= 1'b0;
    rchk(PEND_ADDR, 32'h0);
    chk({31'h0, pin_direct_req}, 32'h1);
    ext_req_n <= 7'h7f;
    // peripheral lines without and with four-slot sharing
    periph_lvls <= lb(26);
    repeat (PBUS_LATENCY + 1) @(posedge clk);
    rchk(PEND_ADDR, lb(5));
    periph_lvls <= 32'h0;
    wr(CFG_ADDR, 32'h0000ffff);
    periph_lvls <= lb(2);
    repeat (PBUS_LATENCY + 1) @(posedge clk);
    rchk(PEND_ADDR, lb(29));
    periph_lvls <= 32'h0;
    // two-slot sharing: slot 1 line 4 is level 12
    wr(CFG_ADDR, 32'h0000fffd);
    periph_lvls <= lb(19);
    repeat (PBUS_LATENCY + 1) @(posedge clk);
    rchk(PEND_ADDR, lb(12));
    periph_lvls <= 32'h0;
    // pin three in edge mode follows the edge latch, not the pin level
    wr(CFG_ADDR, 32'h0040fffc);
    edge_status <= 7'h08;
    rchk(PEND_ADDR, lb(6));
    edge_status <= 7'h00;
    ext_req_n[3] <= 1'b0;
    rchk(PEND_ADDR, 32'h0);
    ext_req_n[3] <= 1'b1;
    wr(CFG_ADDR, 32'h0000fffc);
    // event status: unmapped access, masking, clearing, level rise
    wr(EVT_EN_ADDR, 32'h3);
    wr(EVT_CLR_ADDR, 32'h3);
    rchk(EVT_ST_ADDR, 32'h0);
    xfer(1'b0, 32'h8007eff0, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    rchk(EVT_ST_ADDR, 32'h2);
    ochk(1'b1, 1'b1);
    wr(EVT_EN_ADDR, 32'h1);
    ochk(1'b1, 1'b0);
    wr(EVT_CLR_ADDR, 32'h2);
    rchk(EVT_ST_ADDR, 32'h0);
    ext_req_n[3] <= 1'b0;
    rchk(EVT_ST_ADDR, 32'h1);
    ochk(1'b1, 1'b1);
    chk({31'h0, irq_rises != 0}, 32'h1);
    // reset in mid-run: mask, map, pending levels and the core request must clear again
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk(MASK_ADDR, 32'h0);
    rchk(MAP_ADDR, 32'h0);
    rchk(AND_ADDR, 32'h0);
    rchk(PEND_ADDR, 32'h0);
    ochk(1'b0, 1'b0);
    close_out();
  end
endmodule : tb_level_interrupt_combiner
